// ===== include/sac_regs.svh
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ==========================================
// Clock and conversion timing
`define SAC_CLK_MHZ 100
`define SAC_NORMAL_NS 1000
`define SAC_FAST_NS 500
`define SAC_LOWPWR_NS 1200
// Least times round up to whole cycles
`define SAC_CYC(ns) ((((ns) * `SAC_CLK_MHZ) + 999) / 1000)
`define SAC_NORMAL_CYC `SAC_CYC(`SAC_NORMAL_NS)
`define SAC_FAST_CYC `SAC_CYC(`SAC_FAST_NS)
`define SAC_LOWPWR_CYC `SAC_CYC(`SAC_LOWPWR_NS)
`define SAC_CNT_W 8

// ==========================================
// Data widths and lanes
`define SAC_RES_W 18
`define SAC_WORD_W 16
`define SAC_BYTE_W 8
`define SAC_BITCNT_W 5
`define SAC_LAST_18 5'h11
`define SAC_LAST_16 5'h0F

// ==========================================
// Serial clock and pin synchroniser
`define SAC_SCLK_HALF 3'h4
`define SAC_DIV_W 3
`define SAC_PIN_W 18
// Coding strap idles high, strobes idle high
`define SAC_PINS_RST 18'h0200E

`endif

// ===== include/sac_pkg.sv
package sac_pkg;

	typedef enum logic [1:0]
	{
		SAC_NORMAL = 2'h0,
		SAC_FAST = 2'h1,
		SAC_LOWPWR = 2'h3
	} sac_mode_t;

	typedef enum logic [1:0]
	{
		SAC_IDLE = 2'h0,
		SAC_CONV = 2'h1,
		SAC_ASLEEP = 2'h2
	} sac_state_t;

	typedef struct packed
	{
		logic fast_mode_strap;
		logic low_power_mode_strap;
		logic channel_or_iface_mode_bit0;
		logic byte_swap_or_iface_mode_bit1;
		logic output_coding_select;
		logic interface_select;
		logic serial_clock_source_select;
		logic frame_strobe_polarity;
		logic clock_edge_select;
		logic read_timing_select;
		logic converter_reset;
		logic converter_sleep;
		logic buffer_sleep;
		logic reference_sleep;
		logic convert_start_n;
		logic cs_n;
		logic rd_n;
		logic sclk;
	} sac_pins_t;

endpackage : sac_pkg

// ===== include/sac_ser_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"

interface sac_ser_if;
	logic load;
	logic [`SAC_RES_W-1:0] word;
	logic [`SAC_BITCNT_W-1:0] last_idx;
	logic capture;
	logic launch;
	logic abort;
	logic active;
	logic sdo;

	modport ctl (output load, word, last_idx, capture, launch, abort, input active, sdo);
	modport eng (input load, word, last_idx, capture, launch, abort, output active, sdo);
endinterface : sac_ser_if

`default_nettype wire

// ===== design/sac_serializer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"

module sac_serializer
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Frame engine
	sac_ser_if.eng ser
);
	import sac_pkg::*;

	logic [`SAC_RES_W-1:0] shift_q;
	logic [`SAC_BITCNT_W-1:0] cnt_q;
	logic active_q;

	// ==========================================
	// Shifter: MSB first, new bit after each launch edge
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			shift_q <= '0;
		else if (ser.load)
			shift_q <= ser.word;
		else if (active_q && ser.launch)
			shift_q <= {shift_q[`SAC_RES_W-2:0], 1'h0}; // R10

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cnt_q <= '0;
		else if (ser.load)
			cnt_q <= '0;
		else if (active_q && ser.capture)
			cnt_q <= cnt_q + `SAC_BITCNT_W'(1);

	// Frame ends on the capture edge of the last bit
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			active_q <= 1'h0;
		else if (ser.abort)
			active_q <= 1'h0;
		else if (ser.load)
			active_q <= 1'h1;
		else if (active_q && ser.capture && cnt_q == ser.last_idx)
			active_q <= 1'h0;

	assign ser.active = active_q;
	assign ser.sdo = shift_q[`SAC_RES_W-1];

	// ==========================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_shift_on_launch: assert property ( // R10
		!ser.load && !(active_q && ser.launch) |=> shift_q == $past(shift_q))
		else $error("serial data moved without a launch edge");

endmodule : sac_serializer

`default_nettype wire

// ===== design/sac_top.sv
// How it works
// [R1] Fast strap high, low-power strap low: fastest, shortest conversion.
// [R2] Both mode straps low: normal conversion time.
// [R3] Low-power strap alone: core powers off between conversions.
// [R4] On 18-bit parts the two mode bits pick the output lane arrangement.
// [R5] 16-bit byte mode: swap strap puts the upper byte on low lines.
// [R6] Coding strap low gives two's complement, high gives straight binary.
// [R7] Interface strap low selects parallel bus, high selects serial.
// [R8] Clock-source strap low: device drives serial clock; high: clock is input.
// [R9] Master serial only: polarity strap low gives active-high frame strobe.
// [R10] Edge strap picks the serial clock edge the reader samples on.
// [R11] Read-timing strap: read after conversion, or previous result during it.
// [R12] Converter reset high aborts any conversion; low enables it.
// [R13] Sleep high powers down only after the running conversion ends.
// [R14] Buffer-sleep high turns off the reference buffer.
// [R15] Reference-sleep powers down the reference; buffer must stay enabled then. The code keeps buffer_on tied to buffer_sleep alone.
// [R16] Convert start comes from board logic or an external source.
// [R17] Falling convert start begins a conversion; busy high until result ready.
// [R18] Reader asserts chip select and read together to get parallel data.
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"

module sac_top
#(
	parameter bit RESULT_18BIT = 1'h1
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Mode straps
	input wire logic fast_mode_strap,
	input wire logic low_power_mode_strap,
	input wire logic channel_or_iface_mode_bit0,
	input wire logic byte_swap_or_iface_mode_bit1,
	input wire logic output_coding_select,
	input wire logic interface_select,
	input wire logic serial_clock_source_select,
	input wire logic frame_strobe_polarity,
	input wire logic clock_edge_select,
	input wire logic read_timing_select,
	// Power and abort
	input wire logic converter_reset,
	input wire logic converter_sleep,
	input wire logic buffer_sleep,
	input wire logic reference_sleep,
	// Conversion and parallel read
	input wire logic convert_start_n,
	input wire logic [`SAC_RES_W-1:0] analog_code,
	input wire logic cs_n,
	input wire logic rd_n,
	output logic busy,
	output logic [`SAC_RES_W-1:0] db_o,
	output logic db_oe,
	// Serial port
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe,
	output logic sdout,
	output logic frame_sync,
	// Status
	output sac_pkg::sac_mode_t conv_mode,
	output logic core_powered,
	output logic buffer_on,
	output logic reference_on
);
	import sac_pkg::*;

	localparam logic [`SAC_PIN_W-1:0] PIN_RST = `SAC_PINS_RST;

	logic [1:0] rst_pipe_q;
	logic rst_sync_n;
	logic [`SAC_PIN_W-1:0] pins_raw, s1_q, s2_q, s3_q, filt_q;
	sac_pins_t pin_q;
	sac_state_t state_q;
	sac_mode_t mode_now, mode_q;
	logic [`SAC_CNT_W-1:0] cnt_q, busy_len_q;
	logic [`SAC_RES_W-1:0] sample_q, result_q;
	logic start_prev_q, start_ok, conv_done, rd_en, master;
	logic [`SAC_DIV_W-1:0] div_q;
	logic sclk_q, sclk_prev_q, tgl, rise, fall;
	logic busy_q, db_oe_q, sclk_oe_q, sdout_q, sync_q;
	logic [`SAC_RES_W-1:0] db_q;
	logic powered_q, buf_on_q, ref_on_q;
	sac_mode_t conv_mode_q;

	sac_ser_if ser ();

	// ==========================================
	// Functions
	function automatic sac_mode_t mode_of(input logic fast, input logic lp);
		if (fast && !lp)
			return SAC_FAST; // R1
		else if (lp && !fast)
			return SAC_LOWPWR; // R3
		// Both high is not a legal setting; fall back to normal
		return SAC_NORMAL; // R2
	endfunction : mode_of

	function automatic logic [`SAC_CNT_W-1:0] conv_last(input sac_mode_t m);
		unique case (m)
			SAC_FAST: return `SAC_CNT_W'(`SAC_FAST_CYC - 1);
			SAC_LOWPWR: return `SAC_CNT_W'(`SAC_LOWPWR_CYC - 1);
			default: return `SAC_CNT_W'(`SAC_NORMAL_CYC - 1);
		endcase
	endfunction : conv_last

	function automatic logic [`SAC_RES_W-1:0] code_fmt(input logic [`SAC_RES_W-1:0] c, input logic bin);
		return bin ? c : {~c[`SAC_RES_W-1], c[`SAC_RES_W-2:0]}; // R6
	endfunction : code_fmt

	function automatic logic [`SAC_RES_W-1:0] lanes(input logic [`SAC_RES_W-1:0] r, input logic m0,
		input logic m1);
		logic [`SAC_WORD_W-1:0] w;
		w = r[`SAC_RES_W-1 -: `SAC_WORD_W];
		if (RESULT_18BIT)
			unique case ({m1, m0}) // R4
				2'h0: return r;
				2'h1: return `SAC_RES_W'(w);
				2'h2: return `SAC_RES_W'(r[`SAC_RES_W-1 -: `SAC_BYTE_W]);
				default: return `SAC_RES_W'(r[`SAC_RES_W-`SAC_BYTE_W-1 -: `SAC_BYTE_W]);
			endcase
		// Byte mode on 16-bit parts: swap moves the upper byte down
		return `SAC_RES_W'(m1 ? {w[`SAC_BYTE_W-1:0], w[`SAC_WORD_W-1 -: `SAC_BYTE_W]} : w); // R5
	endfunction : lanes

	// ==========================================
	// Reset release and pin synchronisers
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			rst_pipe_q <= 2'h0;
		else
			rst_pipe_q <= {rst_pipe_q[0], 1'h1};
	assign rst_sync_n = rst_pipe_q[1];

	assign pins_raw = {fast_mode_strap, low_power_mode_strap, channel_or_iface_mode_bit0,
		byte_swap_or_iface_mode_bit1, output_coding_select, interface_select, serial_clock_source_select,
		frame_strobe_polarity, clock_edge_select, read_timing_select, converter_reset, converter_sleep,
		buffer_sleep, reference_sleep, convert_start_n, cs_n, rd_n, sclk_i};

	// A level counts once the second and third stages agree
	for (genvar i = 0; i < `SAC_PIN_W; i++)
	begin : g_pin_sync
		always_ff @(posedge ref_clk or negedge rst_sync_n)
			if (!rst_sync_n)
			begin
				s1_q[i] <= PIN_RST[i];
				s2_q[i] <= PIN_RST[i];
				s3_q[i] <= PIN_RST[i];
				filt_q[i] <= PIN_RST[i];
			end
			else
			begin
				s1_q[i] <= pins_raw[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i])
					filt_q[i] <= s3_q[i];
			end
	end
	assign pin_q = sac_pins_t'(filt_q);

	// ==========================================
	// Conversion sequencer
	assign mode_now = mode_of(pin_q.fast_mode_strap, pin_q.low_power_mode_strap);
	assign start_ok = state_q == SAC_IDLE && start_prev_q && !pin_q.convert_start_n
		&& !pin_q.converter_reset && !pin_q.converter_sleep; // R17 R12
	assign conv_done = state_q == SAC_CONV && cnt_q == '0 && !pin_q.converter_reset;

	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
			start_prev_q <= 1'h1;
		else
			start_prev_q <= pin_q.convert_start_n;

	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
		begin
			state_q <= SAC_IDLE;
			busy_q <= 1'h0;
		end
		else
			unique case (state_q)
				SAC_IDLE:
					if (pin_q.converter_sleep && !pin_q.converter_reset)
						state_q <= SAC_ASLEEP; // R13
					else if (start_ok)
					begin
						state_q <= SAC_CONV;
						busy_q <= 1'h1; // R17
					end
				SAC_CONV:
					// Sleep waits here until the conversion completes
					if (pin_q.converter_reset || conv_done)
					begin
						state_q <= SAC_IDLE; // R12 R13
						busy_q <= 1'h0; // R17
					end
				SAC_ASLEEP:
					if (!pin_q.converter_sleep || pin_q.converter_reset)
						state_q <= SAC_IDLE;
				default:
					state_q <= SAC_IDLE;
			endcase

	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
		begin
			cnt_q <= '0;
			mode_q <= SAC_NORMAL;
		end
		else if (start_ok)
		begin
			cnt_q <= conv_last(mode_now); // R1 R2 R3
			mode_q <= mode_now;
		end
		else if (state_q == SAC_CONV && cnt_q != '0)
			cnt_q <= cnt_q - `SAC_CNT_W'(1);

	// Sample held at start; the result only changes at completion
	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
			sample_q <= '0;
		else if (start_ok)
			sample_q <= analog_code;

	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
			result_q <= '0;
		else if (conv_done)
			result_q <= code_fmt(sample_q, pin_q.output_coding_select); // R6

	// ==========================================
	// Parallel read
	assign rd_en = !pin_q.interface_select && !pin_q.cs_n && !pin_q.rd_n
		&& (pin_q.read_timing_select || !busy_q); // R7 R11 R18

	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
		begin
			db_oe_q <= 1'h0;
			db_q <= '0;
		end
		else
		begin
			db_oe_q <= rd_en;
			if (rd_en)
				db_q <= lanes(result_q, pin_q.channel_or_iface_mode_bit0, pin_q.byte_swap_or_iface_mode_bit1);
		end

	// ==========================================
	// Serial port
	assign master = !pin_q.serial_clock_source_select; // R8
	assign tgl = master && ser.active && div_q == `SAC_SCLK_HALF - `SAC_DIV_W'(1);
	assign rise = master ? tgl && !sclk_q : !sclk_prev_q && pin_q.sclk;
	assign fall = master ? tgl && sclk_q : sclk_prev_q && !pin_q.sclk;

	assign ser.capture = pin_q.clock_edge_select ? rise : fall; // R10
	assign ser.launch = pin_q.clock_edge_select ? fall : rise; // R10
	// Read-during-convert ships the previous result as the new conversion starts
	assign ser.load = pin_q.interface_select && (pin_q.read_timing_select ? start_ok : conv_done); // R11
	assign ser.word = pin_q.read_timing_select ? result_q : code_fmt(sample_q, pin_q.output_coding_select);
	assign ser.last_idx = RESULT_18BIT ? `SAC_LAST_18 : `SAC_LAST_16;
	assign ser.abort = pin_q.converter_reset || !pin_q.interface_select;

	sac_serializer u_ser
	(
		.clk(ref_clk),
		.rst_n(rst_sync_n),
		.ser(ser.eng)
	);

	// Idle level makes the first edge of a frame the capture edge
	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
		begin
			div_q <= '0;
			sclk_q <= 1'h1;
		end
		else if (!ser.active)
		begin
			div_q <= '0;
			sclk_q <= !pin_q.clock_edge_select;
		end
		else if (tgl)
		begin
			div_q <= '0;
			sclk_q <= !sclk_q;
		end
		else
			div_q <= div_q + `SAC_DIV_W'(1);

	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
		begin
			sclk_prev_q <= 1'h0;
			sclk_oe_q <= 1'h0;
			sdout_q <= 1'h0;
			sync_q <= 1'h0;
		end
		else
		begin
			sclk_prev_q <= pin_q.sclk;
			sclk_oe_q <= pin_q.interface_select && master; // R8
			sdout_q <= ser.sdo;
			sync_q <= master ? ser.active ^ pin_q.frame_strobe_polarity : ser.active; // R9
		end

	// ==========================================
	// Status
	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
		begin
			powered_q <= 1'h0;
			buf_on_q <= 1'h0;
			ref_on_q <= 1'h0;
			conv_mode_q <= SAC_NORMAL;
		end
		else
		begin
			powered_q <= state_q != SAC_ASLEEP && !(mode_now == SAC_LOWPWR && state_q == SAC_IDLE); // R3 R13
			buf_on_q <= !pin_q.buffer_sleep; // R14
			ref_on_q <= !pin_q.reference_sleep;
			conv_mode_q <= mode_now;
		end

	assign busy = busy_q;
	assign db_o = db_q;
	assign db_oe = db_oe_q;
	assign sclk_o = sclk_q;
	assign sclk_oe = sclk_oe_q;
	assign sdout = sdout_q;
	assign frame_sync = sync_q;
	assign conv_mode = conv_mode_q;
	assign core_powered = powered_q;
	assign buffer_on = buf_on_q;
	assign reference_on = ref_on_q;

	// ==========================================
	// Checks
	always_ff @(posedge ref_clk or negedge rst_sync_n)
		if (!rst_sync_n)
			busy_len_q <= '0;
		else if (start_ok)
			busy_len_q <= '0;
		else if (busy_q)
			busy_len_q <= busy_len_q + `SAC_CNT_W'(1);

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_sync_n);

	chk_fast_len: assert property ($fell(busy_q) && mode_q == SAC_FAST && !$past(pin_q.converter_reset) // R1
		|-> busy_len_q == `SAC_CNT_W'(`SAC_FAST_CYC)) else $error("fast conversion length wrong");
	chk_normal_len: assert property ($fell(busy_q) && mode_q == SAC_NORMAL && !$past(pin_q.converter_reset) // R2
		|-> busy_len_q == `SAC_CNT_W'(`SAC_NORMAL_CYC)) else $error("normal conversion length wrong");
	chk_lowpwr_len: assert property ($fell(busy_q) && mode_q == SAC_LOWPWR && !$past(pin_q.converter_reset) // R3
		|-> busy_len_q == `SAC_CNT_W'(`SAC_LOWPWR_CYC)) else $error("low power conversion length wrong");
	chk_lowpwr_idle_off: assert property (state_q == SAC_IDLE && mode_now == SAC_LOWPWR // R3
		|=> !core_powered) else $error("core powered while idle in low power mode");
	chk_lane_full: assert property (RESULT_18BIT && rd_en && !pin_q.channel_or_iface_mode_bit0 // R4
		&& !pin_q.byte_swap_or_iface_mode_bit1 |=> db_o == $past(result_q)) else $error("full lane wrong");
	chk_byte_swap: assert property (!RESULT_18BIT && rd_en && pin_q.byte_swap_or_iface_mode_bit1 // R5
		|=> db_o[`SAC_BYTE_W-1:0] == $past(result_q[`SAC_RES_W-1 -: `SAC_BYTE_W])) else $error("swap wrong");
	chk_coding: assert property (conv_done && !pin_q.output_coding_select // R6
		|=> result_q[`SAC_RES_W-1] != $past(sample_q[`SAC_RES_W-1])) else $error("coding MSB wrong");
	chk_serial_no_bus: assert property (pin_q.interface_select |=> !db_oe) // R7
		else $error("parallel bus driven in serial mode");
	chk_sclk_dir: assert property (pin_q.serial_clock_source_select |=> !sclk_oe) // R8
		else $error("serial clock driven while it is an input");
	chk_sync_pol: assert property (master && !ser.active |=> frame_sync == $past(pin_q.frame_strobe_polarity)) // R9
		else $error("frame strobe idle level wrong");
	chk_read_after: assert property (!pin_q.read_timing_select && busy_q |=> !db_oe) // R11
		else $error("read allowed during conversion");
	chk_abort: assert property (pin_q.converter_reset |=> !busy_q ##1 !busy_q) // R12
		else $error("conversion not aborted");
	chk_sleep_wait: assert property (state_q == SAC_CONV && !conv_done && !pin_q.converter_reset // R13
		|=> state_q == SAC_CONV) else $error("conversion cut short");
	chk_sleep_enter: assert property (state_q == SAC_IDLE && pin_q.converter_sleep && !pin_q.converter_reset // R13
		|=> state_q == SAC_ASLEEP ##1 !core_powered) else $error("sleep not entered");
	chk_buf_sleep: assert property (pin_q.buffer_sleep |=> !buffer_on) // R14
		else $error("buffer left on");
	chk_start_busy: assert property (start_ok |=> busy) // R17
		else $error("busy not raised on start");

	cov_conversion: cover property (start_ok ##[1:200] conv_done);
	cov_serial_frame: cover property (ser.load ##[1:1000] $fell(ser.active));
	cov_parallel_read: cover property (rd_en && busy_q);
	cov_sleep: cover property (state_q == SAC_ASLEEP);

endmodule : sac_top

`default_nettype wire

// ===== verif/sac_capture_model.sv
`timescale 1ns/1ps
`default_nettype none

module sac_capture_model
(
	// Clock and control
	input wire logic ref_clk,
	input wire logic clr,
	input wire logic strobe_low,
	input wire logic edge_rise,
	// Serial wires
	input wire logic sclk,
	input wire logic sdout,
	input wire logic frame_sync,
	// Received frame
	output logic [17:0] rx_word,
	output logic [4:0] rx_cnt
);
	logic sclk_q;
	logic act;
	logic cap;

	// ==========================================
	// Receiver
	// Data and strobe taken live: the design's copy of an outside clock lags several cycles
	assign cap = edge_rise ? (!sclk_q && sclk) : (sclk_q && !sclk);
	assign act = frame_sync ^ strobe_low;
	always_ff @(posedge ref_clk)
	begin
		sclk_q <= sclk;
		if (clr)
		begin
			rx_word <= 18'h00000;
			rx_cnt <= 5'h00;
		end
		else if (cap && act)
		begin
			rx_word <= {rx_word[16:0], sdout};
			rx_cnt <= rx_cnt + 5'h01;
		end
	end
endmodule : sac_capture_model

`default_nettype wire

// ===== verif/sar_adc_config_and_readout_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sar_adc_config_and_readout_control_tb;
	import sac_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n, clr, sclk_i, convert_start_n, cs_n, rd_n, sclk_w;
	logic fast_mode_strap, low_power_mode_strap, channel_or_iface_mode_bit0, byte_swap_or_iface_mode_bit1;
	logic output_coding_select, interface_select, serial_clock_source_select, frame_strobe_polarity;
	logic clock_edge_select, read_timing_select, converter_reset, converter_sleep, buffer_sleep, reference_sleep;
	logic [17:0] analog_code, db_o, rx_word;
	logic busy, db_oe, sclk_o, sclk_oe, sdout, frame_sync, core_powered, buffer_on, reference_on;
	logic [4:0] rx_cnt;
	sac_mode_t conv_mode;
	int n_errors = 0;
	int n_checks = 0;
	int lens[4] = '{100, 50, 120, 100};
	logic [1:0] modes[4] = '{2'h0, 2'h1, 2'h3, 2'h0};

	// ==========================================
	// Design and capture side
	sac_top #(.RESULT_18BIT(1'h1)) sac_top_i (.ref_clk, .rst_n, .fast_mode_strap, .low_power_mode_strap,
		.channel_or_iface_mode_bit0, .byte_swap_or_iface_mode_bit1, .output_coding_select, .interface_select,
		.serial_clock_source_select, .frame_strobe_polarity, .clock_edge_select, .read_timing_select,
		.converter_reset, .converter_sleep, .buffer_sleep, .reference_sleep, .convert_start_n, .analog_code,
		.cs_n, .rd_n, .busy, .db_o, .db_oe, .sclk_i, .sclk_o, .sclk_oe, .sdout, .frame_sync, .conv_mode,
		.core_powered, .buffer_on, .reference_on);
	assign sclk_w = sclk_oe ? sclk_o : sclk_i;
	sac_capture_model sac_capture_model_i (.ref_clk, .clr, .strobe_low(frame_strobe_polarity & ~serial_clock_source_select),
		.edge_rise(clock_edge_select), .sclk(sclk_w), .sdout, .frame_sync, .rx_word, .rx_cnt);
	always #5 ref_clk = ~ref_clk;

	// ==========================================
	// Tasks
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick

	task automatic wait_busy(input logic v, input int bound);
		int i;
		i = 0;
		while (busy !== v && i < bound)
		begin
			tick(1);
			i++;
		end
		n_checks++;
		if (busy !== v)
		begin
			$display("[ERR] busy wait expected %b seen %b", v, busy);
			n_errors++;
			report_and_stop();
		end
	endtask : wait_busy

	// Start pin held low three cycles so the synchroniser sees it
	task automatic start(input logic [17:0] code);
		analog_code = code;
		convert_start_n = 1'b0;
		tick(3);
		convert_start_n = 1'b1;
	endtask : start

	task automatic conv(input logic [17:0] code, input int len);
		int n;
		start(code);
		wait_busy(1'b1, 20);
		n = 0;
		while (busy === 1'b1 && n < 400)
		begin
			tick(1);
			n++;
		end
		chk("busy length", 18'(len), 18'(n));
	endtask : conv

	task automatic pread(input logic [17:0] exp);
		int i;
		cs_n = 1'b0;
		rd_n = 1'b0;
		i = 0;
		while (db_oe !== 1'b1 && i < 10)
		begin
			tick(1);
			i++;
		end
		chk("read enable", 18'h1, db_oe);
		chk("parallel data", exp, db_o);
		cs_n = 1'b1;
		rd_n = 1'b1;
		tick(6);
	endtask : pread

	task automatic sframe(input logic [17:0] code, input logic slave);
		int i;
		if (!slave)
		begin
			chk("clock idle", 18'(!clock_edge_select), sclk_o);
			chk("strobe idle", 18'(frame_strobe_polarity), frame_sync);
		end
		clr = 1'b1;
		tick(2);
		clr = 1'b0;
		conv(code, 100);
		if (slave)
		begin
			#1;
			repeat (36) #62.5 sclk_i = ~sclk_i;
		end
		i = 0;
		while (rx_cnt !== 5'h12 && i < 400)
		begin
			tick(1);
			i++;
		end
		tick(4);
		chk("bit count", 18'h12, rx_cnt);
		chk("serial word", code, rx_word);
		chk("clock drive", 18'(!slave), sclk_oe);
	endtask : sframe

	function automatic logic [17:0] lane(input logic [17:0] r, input int m);
		case (m)
			0: return r;
			1: return {2'h0, r[17:2]};
			2: return {10'h000, r[17:10]};
			default: return {10'h000, r[9:2]};
		endcase
	endfunction : lane

	// ==========================================
	// Sequence
	initial
	begin
		{rst_n, clr, fast_mode_strap, low_power_mode_strap, channel_or_iface_mode_bit0} = '0;
		{byte_swap_or_iface_mode_bit1, interface_select, serial_clock_source_select, frame_strobe_polarity} = '0;
		{clock_edge_select, read_timing_select, converter_reset, converter_sleep, buffer_sleep} = '0;
		{reference_sleep, analog_code} = '0;
		{output_coding_select, convert_start_n, cs_n, rd_n, sclk_i} = 5'h1F;
		tick(16);
		rst_n = 1'b1;
		tick(8);
		chk("buffer on", 18'h1, buffer_on);
		chk("reference on", 18'h1, reference_on);
		for (int m = 0; m < 4; m++)
		begin
			fast_mode_strap = m[0];
			low_power_mode_strap = m[1];
			tick(8);
			chk("mode", 18'(modes[m]), 18'(conv_mode));
			conv(18'h3FF00 + 18'(m), lens[m]);
			tick(2);
			chk("core power", 18'(m != 2), core_powered);
		end
		{fast_mode_strap, low_power_mode_strap} = 2'h0;
		tick(8);
		$display("test done: modes");
		conv(18'h2A5C3, 100);
		for (int m = 0; m < 4; m++)
		begin
			{byte_swap_or_iface_mode_bit1, channel_or_iface_mode_bit0} = 2'(m);
			tick(8);
			pread(lane(18'h2A5C3, m));
		end
		{byte_swap_or_iface_mode_bit1, channel_or_iface_mode_bit0} = 2'h0;
		output_coding_select = 1'b0;
		tick(8);
		conv(18'h2A5C3, 100);
		pread(18'h0A5C3);
		output_coding_select = 1'b1;
		$display("test done: parallel");
		start(18'h15A3C);
		wait_busy(1'b1, 20);
		cs_n = 1'b0;
		rd_n = 1'b0;
		tick(10);
		chk("read refused", 18'h0, db_oe);
		{cs_n, rd_n} = 2'h3;
		wait_busy(1'b0, 200);
		pread(18'h15A3C);
		read_timing_select = 1'b1;
		tick(8);
		start(18'h3C3C3);
		wait_busy(1'b1, 20);
		pread(18'h15A3C);
		wait_busy(1'b0, 200);
		read_timing_select = 1'b0;
		tick(8);
		$display("test done: read timing");
		start(18'h00001);
		wait_busy(1'b1, 20);
		tick(20);
		converter_reset = 1'b1;
		wait_busy(1'b0, 8);
		start(18'h00002);
		tick(20);
		chk("start in reset", 18'h0, busy);
		converter_reset = 1'b0;
		tick(8);
		start(18'h00003);
		wait_busy(1'b1, 20);
		converter_sleep = 1'b1;
		tick(20);
		chk("busy in sleep", 18'h1, busy);
		wait_busy(1'b0, 100);
		tick(4);
		chk("asleep", 18'h0, core_powered);
		start(18'h00004);
		tick(20);
		chk("start asleep", 18'h0, busy);
		converter_sleep = 1'b0;
		tick(8);
		chk("awake", 18'h1, core_powered);
		buffer_sleep = 1'b1;
		tick(8);
		chk("buffer off", 18'h0, buffer_on);
		buffer_sleep = 1'b0;
		reference_sleep = 1'b1;
		tick(8);
		chk("reference off", 18'h0, reference_on);
		reference_sleep = 1'b0;
		$display("test done: power");
		interface_select = 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			serial_clock_source_select = (k > 3);
			frame_strobe_polarity = k[0];
			clock_edge_select = (k > 3) ? k[0] : k[1];
			sclk_i = ~clock_edge_select;
			tick(8);
			sframe(18'h2B3C1 ^ 18'(k * 18'h0A5A5), k > 3);
		end
		$display("test done: serial");
		report_and_stop();
	end
endmodule : sar_adc_config_and_readout_control_tb

`default_nettype wire
